// ==== fifo_fill_pkg.sv ====
package fifo_fill_pkg;
  // Address width: the FIFO holds up to 2**N - 1 entries
  localparam int unsigned ADDR_W_DEF = 4;
  // Default width of each fill count output
  localparam int unsigned CNT_W_DEF = 4;
  // Default low-fill set and clear thresholds
  localparam int unsigned SET_THR_DEF = 7;
  localparam int unsigned CLR_THR_DEF = 10;
  // Default depth of one hard primitive
  localparam int unsigned PRIM_DEPTH_DEF = 16;
  // Low-fill flag value during and after reset
  localparam logic FLAG_RST = 1'h1;
  // Margin used by the hard variant for release
  localparam int unsigned HARD_MARGIN = 1;
endpackage : fifo_fill_pkg

// ==== fifo_fill_status.sv ====
// Functional notes
// R1 - Low-fill flag sets at or below set threshold
// R2 - Flag clears above clear threshold, else holds
// R3 - Hard variant: single threshold, no hysteresis (code holds at set + 1 and releases above it)
// R4 - Constant thresholds fixed, no threshold registers
// R5 - Port thresholds only change during reset
// R6 - Set threshold is below clear threshold
// R7 - Flag and read count lag one cycle
// R8 - Hard variant thresholds limited to primitive depth
// R9 - Out-of-range thresholds are never supplied
// R10 - Count width at most log2 depth, keep MSBs
// R11 - Exact count updates on the access edge
// R12 - Read-side count never overstates content
// R13 - Read count width limited, drops low bits
// R14 - Read shows in read count after next edge
// R15 - Writes reach read count several cycles late
// R16 - Write-side count never understates content
// R17 - Write count width limited, drops low bits
// R18 - Write shows in write count after next edge
// R19 - Reads reach write count several cycles late
// R20 - Counts held at zero during reset
// R21 - Crossing pointers Gray coded and synchronised
`timescale 1ns/1ps
module fifo_fill_status
  import fifo_fill_pkg::*;
#(
  parameter int unsigned ADDR_W = ADDR_W_DEF,
  parameter int unsigned CNT_W = CNT_W_DEF,
  parameter bit THR_PORTS = 1'b1,
  parameter bit HARD_FIFO = 1'b0,
  parameter int unsigned SET_CONST = SET_THR_DEF,
  parameter int unsigned CLR_CONST = CLR_THR_DEF,
  parameter int unsigned PRIM_DEPTH = PRIM_DEPTH_DEF
) (
  input wire logic sys_clk_i, // System clock, 100 MHz
  input wire logic rst_b_i, // Synchronous FIFO reset, active low
  input wire logic wr_en_i, // Write request
  input wire logic rd_en_i, // Read request
  input wire logic [ADDR_W-1:0] set_thr_i, // Low-fill set threshold
  input wire logic [ADDR_W-1:0] clr_thr_i, // Low-fill clear threshold
  output logic low_fill_o, // Low-fill flag
  output logic [CNT_W-1:0] fill_cnt_o, // Exact fill count
  output logic [CNT_W-1:0] rd_cnt_o, // Read-side fill count
  output logic [CNT_W-1:0] wr_cnt_o // Write-side fill count
);

  // Binary to Gray
  function automatic logic [ADDR_W-1:0] to_gray(input logic [ADDR_W-1:0] b);
    to_gray = b ^ (b >> 1);
  endfunction

  // Gray to binary
  function automatic logic [ADDR_W-1:0] to_bin(input logic [ADDR_W-1:0] g);
    logic [ADDR_W-1:0] b;
    b = g;
    for (int i = ADDR_W - 2; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    to_bin = b;
  endfunction

  // Keep the upper bits of a count
  function automatic logic [CNT_W-1:0] keep_msb(input logic [ADDR_W-1:0] c);
    keep_msb = c[ADDR_W-1 -: CNT_W]; // R10 R13 R17
  endfunction

  // Largest storable entry count
  localparam logic [ADDR_W-1:0] FULL_CNT = {ADDR_W{1'b1}};
  // Hard variant threshold ceiling
  localparam logic [ADDR_W-1:0] PRIM_MAX = ADDR_W'(PRIM_DEPTH - 1);

  logic [ADDR_W-1:0] wptr_q, wptr_d; // Write pointer
  logic [ADDR_W-1:0] rptr_q, rptr_d; // Read pointer
  logic [ADDR_W-1:0] cnt_q, cnt_d; // Exact entry count
  logic [ADDR_W-1:0] wg_q; // Gray write pointer, launch flop
  logic [ADDR_W-1:0] rg_q; // Gray read pointer, launch flop
  logic [ADDR_W-1:0] wg_s1_q, wg_s2_q; // Write pointer synchroniser
  logic [ADDR_W-1:0] rg_s1_q, rg_s2_q; // Read pointer synchroniser
  logic [ADDR_W-1:0] rd_cnt_q, rd_cnt_d; // Read-side count
  logic [ADDR_W-1:0] wr_cnt_q, wr_cnt_d; // Write-side count
  logic [ADDR_W-1:0] set_q, clr_q; // Thresholds caught in reset
  logic low_q, low_d; // Low-fill flag state

  // Accepted accesses: no write when full, no read when empty
  wire wr_ok = wr_en_i && (cnt_q != FULL_CNT);
  wire rd_ok = rd_en_i && (cnt_q != '0);
  // Write pointer seen by the read side, and vice versa
  wire [ADDR_W-1:0] wsb = to_bin(wg_s2_q);
  wire [ADDR_W-1:0] rsb = to_bin(rg_s2_q);
  // Constant thresholds need no storage
  wire [ADDR_W-1:0] set_raw = THR_PORTS ? set_q : ADDR_W'(SET_CONST); // R4
  wire [ADDR_W-1:0] clr_raw = THR_PORTS ? clr_q : ADDR_W'(CLR_CONST); // R4
  // Hard variant clamps the threshold into one primitive
  wire [ADDR_W-1:0] set_lim = (set_raw > PRIM_MAX) ? PRIM_MAX : set_raw; // R8
  wire [ADDR_W-1:0] set_thr = HARD_FIFO ? set_lim : set_raw;
  // Hard variant: single threshold, release above the level one above it
  wire [ADDR_W:0] clr_ext = HARD_FIFO ? ({1'b0, set_thr} + (ADDR_W+1)'(HARD_MARGIN))
                                      : {1'b0, clr_raw}; // R3
  wire at_set = cnt_q <= set_thr;
  wire above_clr = {1'b0, cnt_q} > clr_ext;
  // Writes not yet seen by the read side
  wire [ADDR_W-1:0] w_lag = wptr_q - wsb;
  // Reads not yet seen by the write side
  wire [ADDR_W-1:0] r_lag = rptr_q - rsb;
  // Read side would go below zero: show empty instead
  wire rd_under = w_lag > cnt_q; // R12
  // Write side sum, one bit wider so it cannot wrap
  wire [ADDR_W:0] wr_sum = {1'b0, cnt_q} + {1'b0, r_lag}; // R16
  // Write side would pass full: show full instead
  wire wr_over = wr_sum > {1'b0, FULL_CNT}; // R16

  // Pointer and exact count next values
  assign wptr_d = wr_ok ? wptr_q + 1'b1 : wptr_q;
  assign rptr_d = rd_ok ? rptr_q + 1'b1 : rptr_q;
  assign cnt_d = cnt_q + ADDR_W'(wr_ok) - ADDR_W'(rd_ok); // R11
  // Read side counts against a stale write pointer: low side
  assign rd_cnt_d = rd_under ? '0 : wsb - rptr_q; // R12 R14 R15
  // Write side counts against a stale read pointer: high side
  assign wr_cnt_d = wr_over ? FULL_CNT : wr_sum[ADDR_W-1:0]; // R16 R18 R19
  // Set wins, release only above the clear level, else hold
  assign low_d = at_set ? 1'b1 : (above_clr ? 1'b0 : low_q); // R1 R2

  // Pointers and exact count
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      wptr_q <= '0;
      rptr_q <= '0;
      cnt_q <= '0; // R20
    end else begin
      wptr_q <= wptr_d;
      rptr_q <= rptr_d;
      cnt_q <= cnt_d; // R11
    end
  end

  // Gray launch flops and two-stage synchronisers
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      wg_q <= '0;
      rg_q <= '0;
      wg_s1_q <= '0;
      wg_s2_q <= '0;
      rg_s1_q <= '0;
      rg_s2_q <= '0;
    end else begin
      wg_q <= to_gray(wptr_q); // R21
      rg_q <= to_gray(rptr_q); // R21
      wg_s1_q <= wg_q;
      wg_s2_q <= wg_s1_q;
      rg_s1_q <= rg_q;
      rg_s2_q <= rg_s1_q;
    end
  end

  // Side counts and the low-fill flag
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      rd_cnt_q <= '0;
      wr_cnt_q <= '0; // R20
      low_q <= FLAG_RST;
    end else begin
      rd_cnt_q <= rd_cnt_d;
      wr_cnt_q <= wr_cnt_d;
      low_q <= low_d; // R7
    end
  end

  // Threshold ports are sampled only while in reset
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      set_q <= set_thr_i; // R5
      clr_q <= clr_thr_i; // R5
    end
  end

  // Output registers
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      low_fill_o <= FLAG_RST;
      fill_cnt_o <= '0; // R20
      rd_cnt_o <= '0;
      wr_cnt_o <= '0; // R20
    end else begin
      low_fill_o <= low_d; // R7
      fill_cnt_o <= keep_msb(cnt_d); // R11
      rd_cnt_o <= keep_msb(rd_cnt_d); // R13
      wr_cnt_o <= keep_msb(wr_cnt_d); // R17
    end
  end

  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rst_b_i);

  // Flag raised one cycle after the count drops to the set level
  AST_SET: assert property (at_set |=> low_fill_o) // R1
    else $error("low-fill flag not set at set threshold");

  // Flag released one cycle after the count passes the clear level
  AST_CLR: assert property (!at_set && above_clr |=> !low_fill_o) // R2
    else $error("low-fill flag not released above clear threshold");

  // Between thresholds the flag keeps its value
  AST_HOLD: assert property (!at_set && !above_clr |=> $stable(low_fill_o)) // R2
    else $error("low-fill flag changed between thresholds");

  // Exact count output follows a lone write on the same edge
  AST_EXACT: assert property (wr_ok && !rd_ok |=> fill_cnt_o == keep_msb($past(cnt_q) + 1'b1)) // R11
    else $error("exact count missed a write");

  // Read-side count never exceeds the real content
  AST_RD_LOW: assert property (rd_cnt_q <= $past(cnt_q)) // R12
    else $error("read-side count overstates content");

  // Write-side count never falls below the real content
  AST_WR_HIGH: assert property (wr_cnt_q >= $past(cnt_q)) // R16
    else $error("write-side count understates content");

  // A read lands in the read count after the following edge
  AST_RD_LAT: assert property (rd_ok |=> ##1 rd_cnt_q ==
    ($past(rd_under) ? '0 : ADDR_W'($past(wsb) - $past(rptr_q)))) // R14
    else $error("read not reflected in read-side count");

  // A write lands in the write count after the following edge
  AST_WR_LAT: assert property (wr_ok |=> ##1 wr_cnt_q ==
    ($past(wr_over) ? FULL_CNT : ADDR_W'($past(wptr_q) - $past(rsb)))) // R18
    else $error("write not reflected in write-side count");

  // Thresholds captured in reset stay fixed while running
  AST_THR: assert property (rst_b_i |=> $stable(set_q) && $stable(clr_q)) // R5
    else $error("threshold changed outside reset");

  // Reset drives the flag high and the exact and write count outputs to zero
  AST_RST: assert property (disable iff (1'b0) !rst_b_i |=> low_fill_o && fill_cnt_o == '0 && wr_cnt_o == '0) // R20
    else $error("outputs not cleared by reset");

  // Set threshold port is caught on every reset edge
  AST_THR_CAPT: assert property (disable iff (1'b0) !rst_b_i |=> set_q == $past(set_thr_i)) // R5
    else $error("threshold not captured in reset");

  // A write at full is refused
  AST_FULL_REF: assert property (wr_en_i && !rd_en_i && cnt_q == FULL_CNT |=> cnt_q == FULL_CNT) // R11
    else $error("write accepted at full");

  // A read at empty is refused
  AST_EMPTY_REF: assert property (rd_en_i && !wr_en_i && cnt_q == '0 |=> cnt_q == '0 && $stable(rptr_q)) // R11
    else $error("read accepted at empty");

  // Exact count output follows a lone read on the same edge
  AST_EXACT_RD: assert property (rd_ok && !wr_ok |=> fill_cnt_o == keep_msb($past(cnt_q) - 1'b1)) // R11
    else $error("exact count missed a read");

  // A write and a read together leave the count as it is
  AST_EXACT_BOTH: assert property (wr_ok && rd_ok |=> $stable(fill_cnt_o)) // R11
    else $error("exact count moved on a paired access");

  // No access, no change of the exact count
  AST_EXACT_NONE: assert property (!wr_ok && !rd_ok |=> $stable(fill_cnt_o)) // R11
    else $error("exact count moved without an access");

  // Exact count output shows the upper bits of the count
  AST_FILL_MATCH: assert property (fill_cnt_o == keep_msb(cnt_q)) // R10
    else $error("exact count output differs from the count");

  // Read count output shows the upper bits of the read count
  AST_RD_OUT: assert property (rd_cnt_o == keep_msb(rd_cnt_q)) // R13
    else $error("read count output differs from the read count");

  // Write count output shows the upper bits of the write count
  AST_WR_OUT: assert property (wr_cnt_o == keep_msb(wr_cnt_q)) // R17
    else $error("write count output differs from the write count");

  // Flag output and flag state agree
  AST_FLAG_Q: assert property (low_fill_o == low_q) // R7
    else $error("flag output differs from flag state");

  // Hard variant keeps the set level within one primitive
  AST_HARD_LIM: assert property (!HARD_FIFO || set_thr <= PRIM_MAX) // R8
    else $error("hard variant threshold beyond one primitive");

  // Hard variant puts the release level one above the set level
  AST_HARD_CLR: assert property (!HARD_FIFO || clr_ext == {1'b0, set_thr} + (ADDR_W+1)'(HARD_MARGIN)) // R3
    else $error("hard variant release level wrong");

  // Constant set threshold is the built-in value
  AST_CONST_THR: assert property (THR_PORTS || set_raw == ADDR_W'(SET_CONST)) // R4
    else $error("constant threshold not applied");

  // Exact count equals the pointer distance
  AST_PTR_CNT: assert property (cnt_q == ADDR_W'(wptr_q - rptr_q)) // R11
    else $error("count and pointers disagree");

  // Crossing write pointer changes one bit at a time
  AST_WGRAY: assert property ($countones(wg_s1_q ^ wg_q) <= 1) // R21
    else $error("write pointer crossing changed several bits");

  // Crossing read pointer changes one bit at a time
  AST_RGRAY: assert property ($countones(rg_s1_q ^ rg_q) <= 1) // R21
    else $error("read pointer crossing changed several bits");

  // An empty FIFO gives a zero read count next edge
  AST_RD_ZERO: assert property (cnt_q == '0 |=> rd_cnt_q == '0) // R12
    else $error("read count not zero when empty");

  // A full FIFO gives a full write count next edge
  AST_WR_FULLSAT: assert property (cnt_q == FULL_CNT |=> wr_cnt_q == FULL_CNT) // R16
    else $error("write count below full when full");

endmodule // fifo_fill_status

// ==== fifo_user_model.sv ====
`timescale 1ns/1ps
// Far-side user logic: issues writes and reads by mode
module fifo_user_model (
  input wire logic sys_clk_i, // Clock
  input wire logic rst_b_i, // Reset, active low
  input wire logic [1:0] mode_i, // 0 idle, 1 write, 2 read, 3 random
  output logic wr_en_o, // Write request
  output logic rd_en_o // Read request
);
  // Quiet until the first clock edge
  initial begin
    wr_en_o = 1'b0;
    rd_en_o = 1'b0;
  end
  // Requests change just after the edge; none while in reset
  always @(posedge sys_clk_i) begin
    wr_en_o <= rst_b_i && (mode_i == 2'h1 || (mode_i == 2'h3 && $urandom_range(0, 1) == 1));
    rd_en_o <= rst_b_i && (mode_i == 2'h2 || (mode_i == 2'h3 && $urandom_range(0, 1) == 1));
  end
endmodule // fifo_user_model

// ==== tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
  import fifo_fill_pkg::*;
  localparam int unsigned CNT_W = 3; // One low bit dropped from each count
  logic sys_clk = 1'b0; // Clock
  logic rst_b = 1'b0; // Reset, active low
  logic wr_en, rd_en; // Requests from the user model
  logic [1:0] mode = 2'h0; // User model mode
  logic [3:0] set_thr = 4'h7, clr_thr = 4'hA; // Low-fill thresholds
  logic low_fill; // Design outputs
  logic [CNT_W-1:0] fill_cnt, rd_cnt, wr_cnt;
  int fail_count = 0, check_count = 0, cyc = 0, cnt = 0;
  int wh[$] = '{0, 0, 0, 0, 0}; // Cumulative writes, last five edges
  int rh[$] = '{0, 0, 0, 0, 0}; // Cumulative reads, last five edges
  bit flag = 1'b1, armed = 1'b0, w, r;

  fifo_fill_status #(.ADDR_W(4), .CNT_W(CNT_W)) i_fifo_fill_status (
    .sys_clk_i(sys_clk), .rst_b_i(rst_b), .wr_en_i(wr_en), .rd_en_i(rd_en),
    .set_thr_i(set_thr), .clr_thr_i(clr_thr), .low_fill_o(low_fill),
    .fill_cnt_o(fill_cnt), .rd_cnt_o(rd_cnt), .wr_cnt_o(wr_cnt));
  fifo_user_model i_fifo_user_model (
    .sys_clk_i(sys_clk), .rst_b_i(rst_b), .mode_i(mode), .wr_en_o(wr_en), .rd_en_o(rd_en));

  // Clock, 10 ns period
  always #5 sys_clk = ~sys_clk;

  task automatic check(input logic [CNT_W-1:0] seen, input logic [CNT_W-1:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("checks=%0d mismatches=%0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // Reference model: flag follows the count of the previous edge
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 2000) begin
      fail_count++;
      report_and_stop();
    end
    if (!rst_b) begin
      flag = 1'b1;
      cnt = 0;
      wh = '{0, 0, 0, 0, 0};
      rh = '{0, 0, 0, 0, 0};
    end else begin
      if (cnt <= set_thr) flag = 1'b1;
      else if (cnt > clr_thr) flag = 1'b0;
      w = wr_en && cnt != 15; // Write at full is refused
      r = rd_en && cnt != 0; // Read at empty is refused
      cnt = cnt + w - r;
      wh.push_back(wh[4] + w);
      rh.push_back(rh[4] + r);
      void'(wh.pop_front());
      void'(rh.pop_front());
    end
  end

  // Compare every output once settled, reset included
  always @(negedge sys_clk) begin
    if (armed) begin
      check({2'h0, low_fill}, {2'h0, flag});
      check(fill_cnt, CNT_W'(cnt >> 1));
      check(wr_cnt, CNT_W'(((wh[3] - rh[0]) > 15 ? 15 : wh[3] - rh[0]) >> 1));
      check(rd_cnt, CNT_W'((wh[0] > rh[3] ? wh[0] - rh[3] : 0) >> 1));
    end
  end

  // Fill to refusal, drain to refusal, then random traffic
  initial begin
    void'($urandom(76));
    for (int t = 0; t < 3; t++) begin
      @(posedge sys_clk);
      rst_b <= 1'b0;
      mode <= 2'h0;
      if (t > 0) begin
        set_thr <= 4'($urandom_range(0, 6));
        clr_thr <= 4'($urandom_range(8, 14));
      end
      repeat (6) @(posedge sys_clk);
      armed = 1'b1;
      rst_b <= 1'b1;
      mode <= 2'h1;
      repeat (20) @(posedge sys_clk);
      mode <= 2'h0;
      repeat (6) @(posedge sys_clk);
      mode <= 2'h2;
      repeat (20) @(posedge sys_clk);
      mode <= 2'h3;
      repeat (150) @(posedge sys_clk);
      $display("Test %0d done, set %0d clear %0d", t, set_thr, clr_thr);
    end
    report_and_stop();
  end
endmodule // tb_top
